// ===== pkg/adc_out_defines.vh
// constants for the dual converter output control block
`ifndef ADC_OUT_DEFINES_VH
`define ADC_OUT_DEFINES_VH

// ----------------------------------------
// data path
// ----------------------------------------
`define CODE_W 14
`define CODE_MSB 13
`define SLOT_W 15
`define RANGE_BIT 14
`define PIPE_STAGES 6
`define PIPE_W 90
`define PIPE_TOP_LSB 75

// ----------------------------------------
// format selection levels
// ----------------------------------------
`define LEVEL_GND 2'h0
`define LEVEL_THIRD 2'h1
`define LEVEL_TWO_THIRDS 2'h2
`define LEVEL_SUPPLY 2'h3

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define REG_IRQ_STATUS 8'h00
`define REG_IRQ_MASK 8'h04
`define REG_CHAN_STATE 8'h08
`define REG_OUT_WORDS 8'h0C

// ----------------------------------------
// interrupt status fields and reset values
// ----------------------------------------
`define EV_A_RANGE 0
`define EV_B_RANGE 1
`define EV_A_WORD 2
`define EV_B_WORD 3
`define EV_W 4
`define IRQ_STATUS_RST 4'h0
`define IRQ_MASK_RST 4'h0

// ----------------------------------------
// channel state fields
// ----------------------------------------
`define ST_FORMAT_LSB 0
`define ST_STAB 2
`define ST_TWOS 3
`define ST_A_LSB 4
`define ST_B_LSB 6
`define CH_NORMAL 2'h0
`define CH_HIZ 2'h1
`define CH_NAP 2'h2
`define CH_SLEEP 2'h3

`endif

// ===== design/dual_adc_output_control.v
// dual converter output control: sampling pipeline, bus swap, power modes, AHB-Lite registers
`timescale 1ns/10ps
// Functional notes
// - each channel samples on own clock rise
// - swap high: A on first, B second
// - swap low: A on second, B first
// - select low, enable low: convert, drive
// - select low, enable high: convert, hi-z
// - select high, enable low: nap, hi-z
// - select high, enable high: sleep, hi-z
// - one format input governs both channels
// - ground: offset binary, stabilizer off
// - one third: offset binary, stabilizer on
// - two thirds: two's complement, stabilizer on
// - supply: two's complement, stabilizer off
// - 14-bit result, bit 13 is MSB
// - range flag high on over/underflow
// - result appears six sample clocks later
`include "adc_out_defines.vh"

module dual_adc_output_control (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	output wire irq,
	input wire chan_a_sample_clock,
	input wire chan_b_sample_clock,
	input wire [13:0] chan_a_sample_code,
	input wire [13:0] chan_b_sample_code,
	input wire chan_a_over_range,
	input wire chan_b_over_range,
	input wire chan_a_under_range,
	input wire chan_b_under_range,
	input wire chan_a_power_down_select,
	input wire chan_b_power_down_select,
	input wire chan_a_output_enable_n,
	input wire chan_b_output_enable_n,
	input wire [1:0] format_select_level,
	input wire bus_swap_select,
	output wire [13:0] first_output_bus,
	output wire first_output_bus_oe,
	output wire first_bus_range_flag,
	output wire first_bus_range_flag_oe,
	output wire [13:0] second_output_bus,
	output wire second_output_bus_oe,
	output wire second_bus_range_flag,
	output wire second_bus_range_flag_oe,
	output wire stabilizer_enable,
	output wire [1:0] chan_a_power_state,
	output wire [1:0] chan_b_power_state
);

// ----------------------------------------
// shared format and stabilizer decode
// ----------------------------------------
wire twos_complement;
wire [1:0] samp_clk;
wire [13:0] samp_code [0:1];
wire [1:0] over_in;
wire [1:0] under_in;
wire [1:0] pd_sel;
wire [1:0] oe_n;
wire [14:0] out_slot [0:1];
wire [1:0] drive_en;
wire [1:0] word_evt;
wire [1:0] range_evt;
wire [1:0] ch_state [0:1];
reg twos_dec;
reg stab_dec;

// one level for both channels
always @* begin
	case (format_select_level)
		`LEVEL_GND: begin
			twos_dec = 1'b0;
			stab_dec = 1'b0;
		end
		`LEVEL_THIRD: begin
			twos_dec = 1'b0;
			stab_dec = 1'b1;
		end
		`LEVEL_TWO_THIRDS: begin
			twos_dec = 1'b1;
			stab_dec = 1'b1;
		end
		`LEVEL_SUPPLY: begin
			twos_dec = 1'b1;
			stab_dec = 1'b0;
		end
		default: begin
			twos_dec = 1'b0;
			stab_dec = 1'b0;
		end
	endcase
end

assign twos_complement = twos_dec;
assign stabilizer_enable = stab_dec;

assign samp_clk = {chan_b_sample_clock, chan_a_sample_clock};
assign samp_code[0] = chan_a_sample_code;
assign samp_code[1] = chan_b_sample_code;
assign over_in = {chan_b_over_range, chan_a_over_range};
assign under_in = {chan_b_under_range, chan_a_under_range};
assign pd_sel = {chan_b_power_down_select, chan_a_power_down_select};
assign oe_n = {chan_b_output_enable_n, chan_a_output_enable_n};

// ----------------------------------------
// per channel pipeline
// ----------------------------------------
genvar ch;
generate
	for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
		reg clk_prev_ff;
		reg [`PIPE_W-1:0] pipe_ff;
		reg [`PIPE_W-1:0] nxt_pipe;
		reg [`SLOT_W-1:0] out_ff;
		reg [`SLOT_W-1:0] nxt_out;
		reg word_evt_ff;
		reg range_evt_ff;
		wire rise;
		wire [`SLOT_W-1:0] in_slot;
		wire [`SLOT_W-1:0] top_slot;
		wire [1:0] mode;
		reg conv_on;
		reg drive_on;

		// rising edge of this channel's own sample clock
		assign rise = samp_clk[ch] & ~clk_prev_ff;
		// code with its range flag travels as one slot
		assign in_slot = {over_in[ch] | under_in[ch], samp_code[ch]};
		assign top_slot = pipe_ff[`PIPE_W-1:`PIPE_TOP_LSB];
		assign mode = {pd_sel[ch], oe_n[ch]};

		// per channel power mode decode
		always @* begin
			case (mode)
				`CH_NORMAL: begin
					conv_on = 1'b1;
					drive_on = 1'b1;
				end
				`CH_HIZ: begin
					conv_on = 1'b1;
					drive_on = 1'b0;
				end
				`CH_NAP: begin
					conv_on = 1'b0;
					drive_on = 1'b0;
				end
				`CH_SLEEP: begin
					conv_on = 1'b0;
					drive_on = 1'b0;
				end
				default: begin
					conv_on = 1'b0;
					drive_on = 1'b0;
				end
			endcase
		end

		always @* begin
			nxt_pipe = pipe_ff;
			nxt_out = out_ff;
			// nap and sleep freeze conversion; hi-z mode keeps converting
			if (rise && conv_on) begin
				nxt_pipe = {pipe_ff[`PIPE_TOP_LSB-1:0], in_slot};
				// six stages, then out register on the following edge
				nxt_out = {top_slot[`RANGE_BIT], top_slot[`CODE_MSB] ^ twos_complement,
					top_slot[`CODE_MSB-1:0]};
			end
		end

		always @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				clk_prev_ff <= 1'b0;
				pipe_ff <= {`PIPE_W{1'b0}};
				out_ff <= {`SLOT_W{1'b0}};
				word_evt_ff <= 1'b0;
				range_evt_ff <= 1'b0;
			end else begin
				clk_prev_ff <= samp_clk[ch];
				pipe_ff <= nxt_pipe;
				out_ff <= nxt_out;
				word_evt_ff <= rise && conv_on;
				range_evt_ff <= rise && conv_on && top_slot[`RANGE_BIT];
			end
		end

		assign out_slot[ch] = out_ff;
		assign word_evt[ch] = word_evt_ff;
		assign range_evt[ch] = range_evt_ff;
		// drive only when converting with output enabled
		assign drive_en[ch] = drive_on;
		assign ch_state[ch] = {pd_sel[ch], oe_n[ch]};
	end
endgenerate

assign chan_a_power_state = ch_state[0];
assign chan_b_power_state = ch_state[1];

// ----------------------------------------
// output bus swap
// ----------------------------------------
wire first_src;

// swap high keeps A on first bus; low exchanges the buses
assign first_src = bus_swap_select ? 1'b0 : 1'b1;
assign first_output_bus = out_slot[first_src][`CODE_MSB:0];
assign first_bus_range_flag = out_slot[first_src][`RANGE_BIT];
assign first_output_bus_oe = drive_en[first_src];
assign first_bus_range_flag_oe = drive_en[first_src];
assign second_output_bus = out_slot[~first_src][`CODE_MSB:0];
assign second_bus_range_flag = out_slot[~first_src][`RANGE_BIT];
assign second_output_bus_oe = drive_en[~first_src];
assign second_bus_range_flag_oe = drive_en[~first_src];

// ----------------------------------------
// AHB-Lite slave, zero wait
// ----------------------------------------
reg wr_pend_ff;
reg [7:0] addr_ff;
reg [`EV_W-1:0] irq_status_ff;
reg [`EV_W-1:0] nxt_irq_status;
reg [`EV_W-1:0] irq_mask_ff;
reg [31:0] rd_mux;
wire addr_take;
wire [`EV_W-1:0] ev_set;
wire [31:0] state_word;

assign addr_take = hsel && hready && htrans[1];
assign hreadyout = 1'b1;
assign hresp = 1'b0;

always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		wr_pend_ff <= 1'b0;
		addr_ff <= 8'h00;
	end else begin
		wr_pend_ff <= addr_take && hwrite;
		if (addr_take) begin
			addr_ff <= haddr;
		end
	end
end

// ----------------------------------------
// interrupt status and mask
// ----------------------------------------
assign ev_set[`EV_A_RANGE] = range_evt[0];
assign ev_set[`EV_B_RANGE] = range_evt[1];
assign ev_set[`EV_A_WORD] = word_evt[0];
assign ev_set[`EV_B_WORD] = word_evt[1];

always @* begin
	nxt_irq_status = irq_status_ff;
	if (wr_pend_ff && addr_ff == `REG_IRQ_STATUS) begin
		nxt_irq_status = irq_status_ff & ~hwdata[`EV_W-1:0];
	end
	// set beats a clear in the same cycle
	nxt_irq_status = nxt_irq_status | ev_set;
end

always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		irq_status_ff <= `IRQ_STATUS_RST;
		irq_mask_ff <= `IRQ_MASK_RST;
	end else begin
		irq_status_ff <= nxt_irq_status;
		if (wr_pend_ff && addr_ff == `REG_IRQ_MASK) begin
			irq_mask_ff <= hwdata[`EV_W-1:0];
		end
	end
end

assign irq = |(irq_status_ff & irq_mask_ff);

// ----------------------------------------
// read data
// ----------------------------------------
assign state_word = {24'h000000, chan_b_power_state, chan_a_power_state,
	twos_complement, stabilizer_enable, format_select_level};

always @* begin
	case (addr_ff)
		`REG_IRQ_STATUS: rd_mux = {28'h0000000, irq_status_ff};
		`REG_IRQ_MASK: rd_mux = {28'h0000000, irq_mask_ff};
		`REG_CHAN_STATE: rd_mux = state_word;
		`REG_OUT_WORDS: rd_mux = {1'b0, out_slot[1], 1'b0, out_slot[0]};
		default: rd_mux = 32'h00000000;
	endcase
end

assign hrdata = rd_mux;

endmodule // dual_adc_output_control

// ===== tb/adc_capture_model.sv
// capture logic model latching each output word with its flag
`timescale 1ns/10ps
module adc_capture_model (
	input wire hclk,
	input wire oe,
	input wire flag,
	input wire [13:0] bus,
	output reg [14:0] word_ff
);
	// released pins read back as the inverse of the last capture
	wire [14:0] pin = oe ? {flag, bus} : ~word_ff;
	always @(posedge hclk) begin
		word_ff <= pin;
	end
endmodule // adc_capture_model

// ===== tb/dual_adc_output_control_asserts.sv
// port checks for the dual converter output control
`timescale 1ns/10ps
module dual_adc_output_control_asserts (
	input wire hclk,
	input wire hresetn,
	input wire bus_swap_select,
	input wire stabilizer_enable,
	input wire chan_a_sample_clock,
	input wire chan_b_sample_clock,
	input wire chan_a_power_down_select,
	input wire chan_b_power_down_select,
	input wire chan_a_output_enable_n,
	input wire chan_b_output_enable_n,
	input wire first_output_bus_oe,
	input wire second_output_bus_oe,
	input wire first_bus_range_flag_oe,
	input wire second_bus_range_flag_oe,
	input wire [1:0] format_select_level,
	input wire [1:0] chan_a_power_state,
	input wire [1:0] chan_b_power_state,
	input wire [13:0] first_output_bus,
	input wire [13:0] second_output_bus
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire a_on = !chan_a_power_down_select && !chan_a_output_enable_n;
	wire b_on = !chan_b_power_down_select && !chan_b_output_enable_n;
	wire idle = !chan_a_sample_clock && !chan_b_sample_clock;
	wire [1:0] lvl = format_select_level;
	stab_level_a: assert property (stabilizer_enable == (lvl == 2'h1 || lvl == 2'h2))
		else $error("stabilizer wrong");
	first_drive_a: assert property (first_output_bus_oe == (bus_swap_select ? a_on : b_on))
		else $error("first enable wrong");
	second_drive_a: assert property (second_output_bus_oe == (bus_swap_select ? b_on : a_on))
		else $error("second enable wrong");
	flag_drive_a: assert property ((first_bus_range_flag_oe == first_output_bus_oe) &&
		(second_bus_range_flag_oe == second_output_bus_oe)) else $error("flag enable wrong");
	a_state_a: assert property (chan_a_power_state == {chan_a_power_down_select, chan_a_output_enable_n})
		else $error("a state wrong");
	b_state_a: assert property (chan_b_power_state == {chan_b_power_down_select, chan_b_output_enable_n})
		else $error("b state wrong");
	swap_data_a: assert property ($changed(bus_swap_select) && idle && $past(idle)
		|-> first_output_bus == $past(second_output_bus)) else $error("swap wrong");
	nap_freeze_a: assert property (chan_a_power_down_select && $past(chan_a_power_down_select)
		&& bus_swap_select && $stable(bus_swap_select) |-> $stable(first_output_bus)) else $error("nap moved");
endmodule // dual_adc_output_control_asserts
bind dual_adc_output_control dual_adc_output_control_asserts chk (.*);

// ===== tb/dual_adc_output_control_tb.sv
// self-checking bench for the dual converter output control
`timescale 1ns/10ps
`include "adc_out_defines.vh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; $display("Error %0t %h %h", $time, a, e); end end
module dual_adc_output_control_tb;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, bus_swap_select = 1, fa, fb, sw;
	logic chan_a_sample_clock = 0, chan_b_sample_clock = 0, chan_a_over_range = 0, chan_b_over_range = 0;
	logic chan_a_under_range = 0, chan_b_under_range = 0, chan_a_power_down_select = 0, chan_b_power_down_select = 0;
	logic chan_a_output_enable_n = 0, chan_b_output_enable_n = 0;
	logic [7:0] haddr = 0;
	logic [1:0] htrans = 0, format_select_level = 0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 0, rd;
	logic [13:0] chan_a_sample_code = 0, chan_b_sample_code = 0, ea, eb, v;
	wire [31:0] hrdata;
	wire [13:0] first_output_bus, second_output_bus;
	wire [1:0] chan_a_power_state, chan_b_power_state;
	wire hreadyout, hresp, irq, first_output_bus_oe, first_bus_range_flag, first_bus_range_flag_oe, stabilizer_enable;
	wire second_output_bus_oe, second_bus_range_flag, second_bus_range_flag_oe;
	wire hready = hreadyout;
	wire [14:0] word_ff;
	int n_mismatch = 0, num_checks = 0, j;
	dual_adc_output_control dut (.*);
	adc_capture_model cap (.hclk(hclk), .oe(first_output_bus_oe), .flag(first_bus_range_flag),
		.bus(first_output_bus), .word_ff(word_ff));
	initial forever #2.5 hclk = ~hclk;
	task close_out;
		if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		{hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, w};
		do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 50);
		{htrans, hwdata} <= {2'h0, d};
		do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 50);
		rd = hrdata;
		if (k >= 50) begin n_mismatch++; close_out(); end
	endtask
	task pulse(input int i);
		{chan_a_sample_clock, chan_b_sample_clock} <= 2'h3;
		chan_a_sample_code <= 14'h0100 + 14'(i);
		chan_b_sample_code <= 14'h2200 + 14'(i);
		{chan_a_over_range, chan_b_over_range, chan_a_under_range, chan_b_under_range} <= {i == 2, i == 3, i == 4, i == 5};
		@(posedge hclk);
		{chan_a_sample_clock, chan_b_sample_clock} <= 2'h0;
		@(posedge hclk);
		#1;
	endtask
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		ahb(1'b1, `REG_IRQ_MASK, 32'h1);
		for (int i = 0; i < 12; i++) begin
			@(posedge hclk);
			sw = (i < 9);
			bus_swap_select <= sw;
			format_select_level <= (i >= 10) ? `LEVEL_TWO_THIRDS : `LEVEL_GND;
			pulse(i);
			j = i - 6;
			ea = (14'h0100 + 14'(j)) ^ {i >= 10, 13'h0};
			eb = (14'h2200 + 14'(j)) ^ {i >= 10, 13'h0};
			fa = (j == 2 || j == 4);
			fb = (j == 3 || j == 5);
			if (i >= 6) begin
				`CHK(first_output_bus, sw ? ea : eb)
				`CHK(second_output_bus, sw ? eb : ea)
				`CHK(second_bus_range_flag, sw ? fb : fa)
				`CHK(word_ff, sw ? {fa, ea} : {fb, eb})
			end
		end
		ahb(1'b0, `REG_OUT_WORDS, 32'h0);
		`CHK(rd, 32'h42052105)
		ahb(1'b0, `REG_CHAN_STATE, 32'h0);
		`CHK(rd, 32'h0E)
		ahb(1'b0, `REG_IRQ_STATUS, 32'h0);
		`CHK({rd, irq}, {32'hF, 1'b1})
		ahb(1'b1, `REG_IRQ_STATUS, 32'hF);
		ahb(1'b0, 8'h40, 32'h0);
		`CHK({rd, irq, hresp}, {32'h0, 1'b0, 1'b0})
		for (int m = 0; m < 4; m++) begin
			@(posedge hclk);
			bus_swap_select <= 1'b1;
			{chan_a_power_down_select, chan_a_output_enable_n} <= 2'(m);
			{chan_b_power_down_select, chan_b_output_enable_n} <= 2'(m);
			format_select_level <= 2'(m);
			pulse(12 + m);
			`CHK(first_output_bus, m < 2 ? 14'h0106 + 14'(m) : v)
			`CHK({first_output_bus_oe, second_output_bus_oe}, {2{m == 0}})
			`CHK({first_bus_range_flag_oe, second_bus_range_flag_oe}, {2{m == 0}})
			`CHK({chan_a_power_state, chan_b_power_state}, {2{2'(m)}})
			`CHK(stabilizer_enable, m == 1 || m == 2)
			v = first_output_bus;
		end
		@(posedge hclk);
		bus_swap_select <= 1'b0;
		@(posedge hclk);
		#1;
		`CHK(second_output_bus, v)
		// swap tied to both sample clocks: one bus carries both channels
		@(posedge hclk);
		{chan_a_power_down_select, chan_a_output_enable_n} <= 2'h0;
		{chan_b_power_down_select, chan_b_output_enable_n} <= 2'h0;
		{bus_swap_select, chan_a_sample_clock, chan_b_sample_clock} <= 3'h7;
		repeat (2) @(posedge hclk);
		{bus_swap_select, chan_a_sample_clock, chan_b_sample_clock} <= 3'h0;
		#1;
		`CHK(word_ff, {1'b0, 14'h2108})
		@(posedge hclk);
		#1;
		`CHK(word_ff, {1'b0, 14'h0208})
		close_out();
	end
endmodule // dual_adc_output_control_tb
